// ==== rtl/foa_align.sv ====
// Operand convention, widening, flush-to-zero and alignment check logic.
module foa_align
  import foa_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Control register value.
  input wire logic [SP_W-1:0] fp_status_control_register,
  // Instruction fetch check.
  input wire logic fetch_valid,
  input wire logic [ADDR_W-1:0] fetch_addr,
  output logic fetch_misalign,
  // Arithmetic operands from issue.
  input wire logic fop_valid,
  input wire foa_fop_t fop,
  output logic fop_illegal,
  output logic [DATA_W-1:0] opa_wide_q,
  output logic [DATA_W-1:0] opb_wide_q,
  output logic [EXP_W-1:0] opa_exp_q,
  output logic fop_out_valid_q,
  output logic res_sp_q,
  // Raw result from the arithmetic unit and its shaped form.
  input wire logic res_valid,
  input wire logic [DATA_W-1:0] res_raw,
  input wire logic res_raw_sp,
  output logic [DATA_W-1:0] res_q,
  output logic res_valid_q,
  output logic non_ieee,
  // Memory access request and answer.
  input wire logic mreq_valid,
  output logic mreq_ready,
  input wire foa_mreq_t mreq,
  output logic mem_valid_q,
  output logic [ADDR_W-1:0] mem_addr_q,
  output foa_size_t mem_size_q,
  output logic mem_we_q,
  output logic [DATA_W-1:0] mem_wdata_q,
  output logic done_q,
  output logic misalign_q,
  output logic align_irq_q
);

  // Non-IEEE mode follows the control bit directly.
  assign non_ieee = fp_status_control_register[NON_IEEE_BIT]; // RL11

  // Fetch addresses are word units and must have clear low bits.
  assign fetch_misalign = fetch_valid && ((fetch_addr[1:0] & WORD_LSB_MASK) != 2'h0); // RL7

  // Single operand widened to double with its value kept exactly.
  // Denormal singles are normal in double range, so they are prenormalized here.
  function automatic logic [DATA_W-1:0] widen(input logic [DATA_W-1:0] v, input logic sp);
    logic [SP_W-1:0] s;
    logic [DP_EXP_W-1:0] e;
    logic [SP_FRAC_W-1:0] fr;
    logic [4:0] lead;
    s = v[SP_W-1:0];
    e = 11'h000;
    fr = s[SP_FRAC_W-1:0];
    lead = 5'h00;
    if (!sp) begin
      return v;
    end
    // Position of the leading one of the fraction, used only for denormals.
    for (int i = 0; i < SP_FRAC_W; i++) begin
      if (s[i]) begin
        lead = 5'(i);
      end
    end
    if (s[SP_W-2 -: SP_EXP_W] == 8'hff) begin
      e = 11'h7ff;
    end else if (s[SP_W-2 -: SP_EXP_W] != 8'h00) begin
      e = {3'h0, s[SP_W-2 -: SP_EXP_W]} + SP_TO_DP_BIAS;
    end else if (fr != '0) begin
      // Shift the leading one out as the hidden bit and lower the exponent to match.
      e = SP_TO_DP_BIAS - 11'(SP_FRAC_W - 1) + 11'(lead);
      fr = fr << (5'(SP_FRAC_W) - lead);
    end
    return {s[SP_W-1], e, fr, 29'h0000_0000}; // RL3
  endfunction

  // Operand stage: double ops widen singles; single ops need single operands.
  logic [DATA_W-1:0] opa_d, opb_d;
  logic [EXP_W-1:0] opa_exp_d;
  logic fop_ov_d, res_sp_d;
  assign fop_illegal = fop_valid && fop.op_sp && !(fop.a_sp && fop.b_sp); // RL2
  always_comb begin
    opa_d = widen(fop.a, fop.a_sp); // RL1
    opb_d = widen(fop.b, fop.b_sp); // RL1
    // Two extra exponent bits, zero-filled above the widened 11-bit exponent.
    opa_exp_d = {2'h0, opa_d[DATA_W-2 -: DP_EXP_W]}; // RL4
    fop_ov_d = fop_valid && !fop_illegal;
    res_sp_d = fop.op_sp; // RL2
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opa_wide_q <= '0;
      opb_wide_q <= '0;
      opa_exp_q <= '0;
      fop_out_valid_q <= 1'b0;
      res_sp_q <= 1'b0;
    end else begin
      opa_wide_q <= opa_d;
      opb_wide_q <= opb_d;
      opa_exp_q <= opa_exp_d;
      fop_out_valid_q <= fop_ov_d;
      res_sp_q <= res_sp_d;
    end
  end

  // Result shaping: flush denormals to zero in non-IEEE mode, any rounding mode.
  logic [DATA_W-1:0] res_d;
  logic res_v_d, den;
  always_comb begin
    res_d = res_raw;
    if (res_raw_sp) begin
      den = (res_raw[SP_W-2 -: SP_EXP_W] == 8'h00) && (res_raw[SP_FRAC_W-1:0] != '0);
      if (non_ieee && den) begin
        res_d = {32'h0000_0000, res_raw[SP_W-1], 31'h0000_0000}; // RL12
      end
    end else begin
      den = (res_raw[DATA_W-2 -: DP_EXP_W] == 11'h000) && (res_raw[DP_FRAC_W-1:0] != '0);
      if (non_ieee && den) begin
        res_d = {res_raw[DATA_W-1], 63'h0}; // RL12
      end
    end
    res_v_d = res_valid; // RL10
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_q <= '0;
      res_valid_q <= 1'b0;
    end else begin
      res_q <= res_d;
      res_valid_q <= res_v_d;
    end
  end

  // Memory path: alignment check, then issue, possibly after a penalty wait.
  foa_state_t st_q, st_d;
  logic [1:0] cnt_q, cnt_d;
  logic mis, fp_mis, dw_mis;
  logic mv_d, we_d, done_d, mis_d, irq_d;
  logic [ADDR_W-1:0] ma_d;
  foa_size_t ms_d;
  logic [DATA_W-1:0] mw_d;
  logic [2:0] size_mask;
  always_comb begin
    // Operand length 2**size; address is its lowest byte.
    size_mask = 3'((4'h1 << mreq.size) - 4'h1); // RL5
    mis = (mreq.addr[2:0] & size_mask) != 3'h0; // RL6
    fp_mis = mreq.is_fp && ((mreq.addr[1:0] & WORD_LSB_MASK) != 2'h0); // RL8
    dw_mis = (mreq.addr[2:0] & DW_LSB_MASK) != 3'h0;
    st_d = st_q;
    cnt_d = cnt_q;
    mv_d = 1'b0;
    we_d = 1'b0;
    done_d = 1'b0;
    mis_d = 1'b0;
    irq_d = 1'b0;
    ma_d = mem_addr_q;
    ms_d = mem_size_q;
    mw_d = mem_wdata_q;
    mreq_ready = (st_q == FOA_IDLE);
    case (st_q)
      FOA_IDLE: begin
        if (mreq_valid) begin
          mis_d = mis;
          if (fp_mis) begin
            irq_d = 1'b1; // RL8
            done_d = 1'b1; // RL13
          end else if (dw_mis) begin
            cnt_d = MISALIGN_PENALTY; // RL9
            st_d = FOA_WAIT;
            ma_d = mreq.addr;
            ms_d = mreq.size;
            we_d = mreq.is_store;
            mw_d = mreq.wdata;
          end else begin
            mv_d = 1'b1;
            we_d = mreq.is_store;
            ma_d = mreq.addr;
            ms_d = mreq.size;
            mw_d = mreq.wdata;
            done_d = 1'b1;
          end
        end
      end
      FOA_WAIT: begin
        we_d = mem_we_q;
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          st_d = FOA_DONE;
        end
      end
      FOA_DONE: begin
        mv_d = 1'b1;
        we_d = mem_we_q;
        done_d = 1'b1;
        st_d = FOA_IDLE;
      end
      default: begin
        st_d = FOA_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= FOA_IDLE;
      cnt_q <= 2'h0;
      mem_valid_q <= 1'b0;
      mem_we_q <= 1'b0;
      done_q <= 1'b0;
      misalign_q <= 1'b0;
      align_irq_q <= 1'b0;
      mem_addr_q <= '0;
      mem_size_q <= FOA_SZ_BYTE;
      mem_wdata_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      mem_valid_q <= mv_d;
      mem_we_q <= we_d;
      done_q <= done_d;
      misalign_q <= mis_d;
      align_irq_q <= irq_d;
      mem_addr_q <= ma_d;
      mem_size_q <= ms_d;
      mem_wdata_q <= mw_d;
    end
  end

  // Checks on the memory, result, operand and fetch paths.
  AST_FP_MIS_IRQ: assert property (@(posedge clk) disable iff (!rstn) // RL8
    (mreq_valid && mreq_ready && mreq.is_fp && mreq.addr[1:0] != 2'h0) |=> align_irq_q)
    else $error("fp misaligned access did not raise alignment interrupt");
  AST_NO_MEM_ON_IRQ: assert property (@(posedge clk) disable iff (!rstn) // RL13
    align_irq_q |-> !mem_valid_q)
    else $error("memory accessed on alignment fault");
  AST_MISALIGN_FLAG: assert property (@(posedge clk) disable iff (!rstn) // RL6
    (mreq_valid && mreq_ready && mreq.size == FOA_SZ_WORD && mreq.addr[1:0] == 2'h2)
    |=> misalign_q)
    else $error("misaligned word not flagged");
  AST_DW_PENALTY: assert property (@(posedge clk) disable iff (!rstn) // RL9
    (mreq_valid && mreq_ready && !mreq.is_fp && mreq.addr[2:0] == 3'h4)
    |=> !mem_valid_q ##1 !mem_valid_q ##1 !mem_valid_q ##1 mem_valid_q)
    else $error("penalty access timing wrong");
  AST_ALIGNED_FAST: assert property (@(posedge clk) disable iff (!rstn) // RL9
    (mreq_valid && mreq_ready && mreq.addr[2:0] == 3'h0) |=> mem_valid_q)
    else $error("aligned access not issued next cycle");
  AST_FETCH: assert property (@(posedge clk) disable iff (!rstn) // RL7
    (fetch_valid && fetch_addr[0]) |-> fetch_misalign)
    else $error("odd fetch address not flagged");
  AST_FTZ: assert property (@(posedge clk) disable iff (!rstn) // RL12
    (res_valid && non_ieee && !res_raw_sp && res_raw[62:52] == 11'h000)
    |=> res_q[62:0] == 63'h0)
    else $error("denormal not flushed");
  AST_IEEE_KEEP: assert property (@(posedge clk) disable iff (!rstn) // RL11
    (res_valid && !non_ieee) |=> res_q == $past(res_raw))
    else $error("result altered in IEEE mode");
  AST_SP_REJECT: assert property (@(posedge clk) disable iff (!rstn) // RL2
    (fop_valid && fop.op_sp && !fop.a_sp) |=> !fop_out_valid_q)
    else $error("single op accepted double operand");
  AST_WIDEN_EXP: assert property (@(posedge clk) disable iff (!rstn) // RL3
    (fop_valid && fop.a_sp && fop.a[30:23] == 8'h7f) |=> opa_exp_q == 13'h03ff)
    else $error("widened exponent wrong");
  COV_FP_IRQ: cover property (@(posedge clk) disable iff (!rstn) align_irq_q);
  COV_PENALTY: cover property (@(posedge clk) disable iff (!rstn) st_q == FOA_WAIT);
  COV_FTZ: cover property (@(posedge clk) disable iff (!rstn) res_valid && non_ieee);
endmodule

// ==== rtl/foa_pkg.sv ====
// Package with constants, types and notes for the floating-point operand alignment block.
// Functional notes
// RL1 - Double-precision operations accept single operands and always return double results.
// RL2 - Single-precision operations take only single operands and return single results.
// RL3 - Single operands widen to double in hardware; narrowing is left to software.
// RL4 - Exponent datapath carries two bits beyond the stored 11-bit exponent.
// RL5 - Bytes numbered from zero; operand address is its lowest-numbered byte.
// RL6 - Operand alignment boundary equals its length; non-multiples are flagged misaligned.
// RL7 - Instructions are 32 bits wide and fetch addresses must be word multiples.
// RL8 - Non-word-aligned floating-point accesses are not performed; alignment interrupt raised.
// RL9 - Accesses not double-word aligned may take extra cycles; results are unchanged.
// RL10 - All single and double operations are supported in every rounding mode.
// RL11 - Control bit 29 set selects non-IEEE mode; clear selects IEEE behaviour.
// RL12 - In non-IEEE mode a denormalized result is replaced by zero.
// RL13 - A faulted access leaves memory and target register unmodified.
package foa_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int SP_W = 32;
  localparam int DP_EXP_W = 11;
  localparam int SP_EXP_W = 8;
  localparam int SP_FRAC_W = 23;
  localparam int DP_FRAC_W = 52;
  localparam int EXP_EXTRA = 2;
  localparam int EXP_W = DP_EXP_W + EXP_EXTRA;
  localparam int NON_IEEE_BIT = 29;
  localparam logic [DP_EXP_W-1:0] DP_BIAS = 11'h3ff;
  localparam logic [DP_EXP_W-1:0] SP_TO_DP_BIAS = 11'h380;
  localparam logic [1:0] WORD_LSB_MASK = 2'h3;
  localparam logic [2:0] DW_LSB_MASK = 3'h7;
  localparam logic [1:0] MISALIGN_PENALTY = 2'h2;

  // Operand size of a memory access, encoded as log2 of the byte count.
  typedef enum logic [1:0] {
    FOA_SZ_BYTE = 2'h0,
    FOA_SZ_HALF = 2'h1,
    FOA_SZ_WORD = 2'h2,
    FOA_SZ_DWORD = 2'h3
  } foa_size_t;

  // Access path state, one-hot.
  typedef enum logic [2:0] {
    FOA_IDLE = 3'b001,
    FOA_WAIT = 3'b010,
    FOA_DONE = 3'b100
  } foa_state_t;

  // Memory request from issue.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    foa_size_t size;
    logic is_fp;
    logic is_store;
    logic [DATA_W-1:0] wdata;
  } foa_mreq_t;

  // Arithmetic operands with their precision tags.
  typedef struct packed {
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic a_sp;
    logic b_sp;
    logic op_sp;
  } foa_fop_t;
endpackage

// ==== verif/foa_mem_model.sv ====
// Behavioural load/store memory that records the stores the block performs.
module foa_mem_model
  import foa_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Access from the block.
  input wire logic mem_valid_q,
  input wire logic [ADDR_W-1:0] mem_addr_q,
  input wire logic mem_we_q,
  input wire logic [DATA_W-1:0] mem_wdata_q,
  // Bookkeeping seen by the bench.
  output int wr_cnt,
  output logic [ADDR_W-1:0] last_addr,
  output logic [DATA_W-1:0] last_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Only performed stores change memory, so a faulted store leaves the count alone.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_cnt <= 0;
      last_addr <= '1;
      last_data <= '1;
    end else if (mem_valid_q && mem_we_q) begin
      wr_cnt <= wr_cnt + 1;
      last_addr <= mem_addr_q;
      last_data <= mem_wdata_q;
    end
  end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the operand alignment block.
module testbench
  import foa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, fetch_valid, fetch_misalign, fop_valid, fop_illegal, fop_out_valid_q;
  logic res_sp_q, res_valid, res_raw_sp, res_valid_q, non_ieee, mreq_valid, mreq_ready;
  logic mem_valid_q, mem_we_q, done_q, misalign_q, align_irq_q;
  logic [SP_W-1:0] fp_status_control_register;
  logic [ADDR_W-1:0] fetch_addr, mem_addr_q, last_addr;
  logic [DATA_W-1:0] opa_wide_q, opb_wide_q, res_raw, res_q, mem_wdata_q, last_data;
  logic [EXP_W-1:0] opa_exp_q;
  foa_fop_t fop;
  foa_mreq_t mreq;
  foa_size_t mem_size_q;
  int wr_cnt, error_cnt, n_compared;

  foa_align i_dut (
    .clk(clk),
    .rstn(rstn),
    .fp_status_control_register(fp_status_control_register),
    .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr),
    .fetch_misalign(fetch_misalign),
    .fop_valid(fop_valid),
    .fop(fop),
    .fop_illegal(fop_illegal),
    .opa_wide_q(opa_wide_q),
    .opb_wide_q(opb_wide_q),
    .opa_exp_q(opa_exp_q),
    .fop_out_valid_q(fop_out_valid_q),
    .res_sp_q(res_sp_q),
    .res_valid(res_valid),
    .res_raw(res_raw),
    .res_raw_sp(res_raw_sp),
    .res_q(res_q),
    .res_valid_q(res_valid_q),
    .non_ieee(non_ieee),
    .mreq_valid(mreq_valid),
    .mreq_ready(mreq_ready),
    .mreq(mreq),
    .mem_valid_q(mem_valid_q),
    .mem_addr_q(mem_addr_q),
    .mem_size_q(mem_size_q),
    .mem_we_q(mem_we_q),
    .mem_wdata_q(mem_wdata_q),
    .done_q(done_q),
    .misalign_q(misalign_q),
    .align_irq_q(align_irq_q)
  );
  foa_mem_model i_mem (
    .clk(clk),
    .rstn(rstn),
    .mem_valid_q(mem_valid_q),
    .mem_addr_q(mem_addr_q),
    .mem_we_q(mem_we_q),
    .mem_wdata_q(mem_wdata_q),
    .wr_cnt(wr_cnt),
    .last_addr(last_addr),
    .last_data(last_data)
  );

  // Free-running core clock.
  initial clk = 0;
  always #2 clk = ~clk;

  // Compare one result against its expected value.
  task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic results();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Every fetch address off a word multiple is flagged.
  task automatic t_fetch();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      fetch_valid = 1;
      fetch_addr = 32'h0000_0100 + i;
      #1 chk("fetch_misalign", i != 0, fetch_misalign);
    end
    @(negedge clk);
    fetch_valid = 0;
  endtask

  // Issue one operand pair; an illegal single op must not produce output.
  task automatic fop_go(logic [63:0] a, logic [63:0] b, logic as, logic bs, logic os);
    logic bad;
    bad = os & !(as & bs);
    @(negedge clk);
    fop_valid = 1;
    fop = '{a, b, as, bs, os};
    #1 chk("fop_illegal", bad, fop_illegal);
    @(posedge clk);
    #1 chk("fop_out_valid_q", !bad, fop_out_valid_q);
  endtask

  // Widening of single operands into double and single ops.
  task automatic t_fop();
    fop_go(64'h0000_0000_3f80_0000, 64'h4000_0000_0000_0000, 1, 0, 0);
    chk("opa_wide_q", 64'h3ff0_0000_0000_0000, opa_wide_q);
    chk("opb_wide_q", 64'h4000_0000_0000_0000, opb_wide_q);
    chk("opa_exp_q", 64'h0000_0000_0000_03ff, opa_exp_q);
    chk("res_sp_q", 0, res_sp_q);
    fop_go(64'h0000_0000_c040_0000, 64'h0000_0000_3f80_0000, 1, 1, 1);
    chk("opa_wide_q", 64'hc008_0000_0000_0000, opa_wide_q);
    chk("res_sp_q", 1, res_sp_q);
    fop_go(64'h0000_0000_3f80_0000, 64'h4000_0000_0000_0000, 1, 0, 1);
    // Denormal singles come out as normal doubles of the same value.
    fop_go(64'h0000_0000_0040_0000, 64'h0000_0000_0000_0001, 1, 1, 1);
    chk("opa_wide_q", 64'h3800_0000_0000_0000, opa_wide_q);
    chk("opb_wide_q", 64'h36a0_0000_0000_0000, opb_wide_q);
    chk("opa_exp_q", 64'h0000_0000_0000_0380, opa_exp_q);
    @(negedge clk);
    fop_valid = 0;
  endtask

  // Result shaping under the mode bit.
  task automatic t_res(logic [31:0] csr, logic sp, logic [63:0] raw, logic [63:0] exp);
    @(negedge clk);
    fp_status_control_register = csr;
    res_raw_sp = sp;
    res_valid = 1;
    res_raw = raw;
    #1 chk("non_ieee", csr[NON_IEEE_BIT], non_ieee);
    @(posedge clk);
    #1 chk("res_valid_q", 1, res_valid_q);
    chk("res_q", exp, res_q);
    @(negedge clk);
    res_valid = 0;
  endtask

  // One memory request; latency, interrupt and the store seen by memory.
  task automatic t_mem(logic [31:0] a, foa_size_t sz, logic fp, logic st);
    int n, w0, lat;
    logic irq, mis, rdy;
    irq = fp && a[1:0] != 2'h0;
    lat = (irq || a[2:0] == 3'h0) ? 1 : 4;
    w0 = wr_cnt;
    @(negedge clk);
    mreq_valid = 1;
    mreq = '{a, sz, fp, st, {a, ~a}};
    #1 chk("mreq_ready", 1, mreq_ready);
    // Taken at this edge; the flag pulses stand only until the next edge.
    @(posedge clk);
    #1 mis = misalign_q;
    rdy = mreq_ready;
    n = 1;
    @(negedge clk);
    mreq_valid = 0;
    while (done_q !== 1'b1 && n < 9) begin
      @(posedge clk);
      #1 n++;
    end
    chk("latency", lat, n);
    chk("mreq_ready", lat == 1, rdy);
    chk("align_irq_q", irq, align_irq_q);
    chk("mem_valid_q", !irq, mem_valid_q);
    chk("misalign_q", (a & ((32'h1 << sz) - 1)) != 0, mis);
    if (!irq) begin
      chk("mem_addr_q", a, mem_addr_q);
      chk("mem_size_q", sz, mem_size_q);
      chk("mem_we_q", st, mem_we_q);
    end
    @(posedge clk);
    #1 chk("writes", w0 + (st & !irq), wr_cnt);
    if (st && !irq) begin
      chk("last_data", {a, ~a}, last_data);
      chk("last_addr", a, last_addr);
    end
  endtask

  // Watchdog against a hung handshake.
  initial begin
    #8000;
    error_cnt++;
    results();
  end

  // Main sequence.
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rstn = 0;
    fetch_valid = 0;
    fetch_addr = '0;
    fop_valid = 0;
    fop = '0;
    res_valid = 0;
    res_raw = '0;
    res_raw_sp = 0;
    mreq_valid = 0;
    mreq = '0;
    fp_status_control_register = '0;
    repeat (4) @(negedge clk);
    rstn = 1;
    t_fetch();
    t_fop();
    t_res(32'h2000_0000, 0, 64'h8000_0000_0000_0001, 64'h8000_0000_0000_0000);
    t_res(32'h0000_0000, 0, 64'h8000_0000_0000_0001, 64'h8000_0000_0000_0001);
    t_res(32'h2000_0000, 0, 64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0000);
    t_res(32'h2000_0000, 1, 64'h0000_0000_8000_0001, 64'h0000_0000_8000_0000);
    t_mem(32'h0000_0010, FOA_SZ_DWORD, 1, 1);
    t_mem(32'h0000_0006, FOA_SZ_WORD, 1, 1);
    t_mem(32'h0000_000c, FOA_SZ_DWORD, 1, 0);
    t_mem(32'h0000_0004, FOA_SZ_WORD, 0, 1);
    t_mem(32'h0000_0021, FOA_SZ_HALF, 0, 1);
    t_mem(32'h0000_0033, FOA_SZ_BYTE, 0, 0);
    results();
  end
endmodule
